// >>> core/tsm_pkg.sv
/*
 Shared constants and types for the sensor message handler: message and
 command identifiers, frame bytes, message lengths, register offsets,
 field positions, reset values and the message kind enumeration.
 Assumes nothing of its surroundings.
*/
package tsm_pkg;
   localparam logic [7:0] MID_EOV2     = 8'h04;
   localparam logic [7:0] MID_ACK      = 8'h08;
   localparam logic [7:0] MID_TDO      = 8'h09;
   localparam logic [7:0] MID_STR      = 8'h07;
   localparam logic [7:0] CMD_RESET    = 8'h10;
   localparam logic [7:0] CMD_TDO      = 8'h11;
   localparam logic [7:0] CMD_SELFTEST = 8'h07;
   localparam logic [7:0] SYNC_SECOND  = 8'h5a;
   localparam logic [7:0] SYNC_FIRST_RST = 8'haa;
   localparam logic [7:0] LEN_ACK      = 8'h01;
   localparam logic [7:0] LEN_EOV      = 8'h02;
   localparam logic [7:0] LEN_STR      = 8'h03;
   localparam logic [7:0] LEN_TDO      = 8'h79;
   localparam logic [6:0] SCAN_SEG     = 7'h1e;
   localparam logic [6:0] SCAN_TOTAL   = 7'h78;
   localparam logic [7:0] INT_MAX      = 8'h7f;
   localparam int         FAULT_W      = 12;
   localparam int         FB_PROG_IMAGE_CHECK = 0;
   localparam int         FB_PARAM_IMAGE      = 1;
   localparam int         FB_INT_RAM          = 2;
   localparam int         FB_EXT_RAM          = 3;
   localparam int         FB_MOTOR            = 4;
   localparam int         FB_SUPPLY_5V        = 5;
   localparam int         FB_PHOTODIODE_TEMP  = 6;
   localparam int         FB_AIR_TEMP         = 7;
   localparam int         FB_CALIBRATION      = 8;
   localparam int         FB_THRESHOLD        = 9;
   localparam int         FB_HIGH_VOLTAGE     = 10;
   localparam int         FB_MIN_RANGE_WARNING = 11;
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_STATUS   = 8'h04;
   localparam logic [7:0] OFF_INTSTAT  = 8'h08;
   localparam logic [7:0] OFF_INTEN    = 8'h0c;
   localparam logic [7:0] OFF_INTCLR   = 8'h10;
   localparam int         NUM_EV       = 4;
   localparam int         EV_CMD       = 0;
   localparam int         EV_DROP      = 1;
   localparam int         EV_STR       = 2;
   localparam int         EV_EOV       = 3;
   localparam logic       CTRL_EN_RST  = 1'b1;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   typedef enum logic [1:0] {K_ACK, K_EOV, K_STR, K_TDO} msg_t;
   typedef enum logic [2:0] {F_IDLE, F_SYNC1, F_SYNC2, F_BODY, F_CSUM} fstate_t;
endpackage : tsm_pkg

// >>> core/frame_rx.sv
/*
 Receive framer: hunts for the two sync bytes, takes one command byte and
 checks the checksum byte, then pulses either a good command or a drop.
 Assumes byte strobes arrive from a receiver on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_rx import tsm_pkg::*; (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [7:0] syncFirst,
   input  wire logic       rxValid,
   input  wire logic [7:0] rxData,
   output logic            cmdValid,
   output logic [7:0]      cmdId,
   output logic            badFrame
);
   typedef struct packed {
      fstate_t    st;
      logic [7:0] id;
      logic       ok;
      logic       bad;
   } rx_t;
   rx_t q, d;
   always_comb begin
      d = q;
      d.ok = 1'b0;
      d.bad = 1'b0;
      if (rxValid) begin
         unique case (q.st)
            F_IDLE:  if (rxData == syncFirst) d.st = F_SYNC2;
            F_SYNC2: if (rxData == SYNC_SECOND) d.st = F_BODY;
                     else if (rxData != syncFirst) d.st = F_IDLE;
            F_BODY: begin
               d.id = rxData;
               d.st = F_CSUM;
            end
            default: begin
               d.ok = (rxData == q.id);
               d.bad = (rxData != q.id);
               d.st = F_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) q <= '{st: F_IDLE, default: '0};
      else q <= d;
   end
   assign cmdValid = q.ok;
   assign cmdId = q.id;
   assign badFrame = q.bad;
endmodule : frame_rx
`default_nettype wire

// >>> core/frame_tx.sv
/*
 Transmit framer: sends two sync bytes, the message bytes fetched by index,
 then the exclusive-OR of the message bytes, under valid/ready flow control.
 Assumes msgByte follows msgIdx combinationally and stays put for a frame.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_tx import tsm_pkg::*; (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [7:0] syncFirst,
   input  wire logic       start,
   input  wire logic [7:0] msgLen,
   input  wire logic [7:0] msgByte,
   output logic [7:0]      msgIdx,
   output logic            done,
   output logic            txValid,
   output logic [7:0]      txData,
   input  wire logic       txReady
);
   typedef struct packed {
      fstate_t    st;
      logic [7:0] idx;
      logic [7:0] sum;
      logic [7:0] dat;
      logic       done;
   } tx_t;
   tx_t q, d;
   always_comb begin
      d = q;
      d.done = 1'b0;
      if (q.st == F_IDLE) begin
         if (start) begin
            d.st = F_SYNC1;
            d.dat = syncFirst;
            d.idx = 8'h00;
         end
      end else if (txReady) begin
         unique case (q.st)
            F_SYNC1: begin
               d.st = F_SYNC2;
               d.dat = SYNC_SECOND;
            end
            F_SYNC2: begin
               d.st = F_BODY;
               d.dat = msgByte;
               d.sum = msgByte;
               d.idx = 8'h01;
            end
            F_BODY: if (q.idx == msgLen) begin
               d.st = F_CSUM;
               d.dat = q.sum;
            end else begin
               d.dat = msgByte;
               d.sum = q.sum ^ msgByte;
               d.idx = q.idx + 8'h01;
            end
            default: begin
               d.st = F_IDLE;
               d.done = 1'b1;
            end
         endcase
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) q <= '{st: F_IDLE, default: '0};
      else q <= d;
   end
   assign msgIdx = q.idx;
   assign done = q.done;
   assign txValid = (q.st != F_IDLE);
   assign txData = q.dat;
endmodule : frame_tx
`default_nettype wire

// >>> core/traffic_sensor_msg_handler.sv
/*
 Message handler top: decodes commands from the receive framer, keeps the
 scan table and pending replies, builds each outgoing message and offers
 control, status and interrupt registers over AXI4-Lite.
 Assumes byte links, scan writes and fault reports on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module traffic_sensor_msg_handler import tsm_pkg::*; (
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic [7:0]         awaddr,
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   input  wire logic [7:0]         araddr,
   input  wire logic               arvalid,
   output logic                    arready,
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire logic               rready,
   input  wire logic               rxValid,
   input  wire logic [7:0]         rxData,
   output logic                    txValid,
   output logic [7:0]              txData,
   input  wire logic               txReady,
   input  wire logic               eovDone,
   input  wire logic [7:0]         vehicleId,
   input  wire logic               faultValid,
   input  wire logic [FAULT_W-1:0] faultBits,
   output logic                    selfTestStart,
   output logic                    devResetReq,
   input  wire logic               scanWe,
   input  wire logic [6:0]         scanAddr,
   input  wire logic [7:0]         scanWdata,
   output logic                    irq
);
   typedef struct packed {
      logic [119:0][7:0]  scan;
      logic               ctrlEn;
      logic [7:0]         syncFirst;
      logic [NUM_EV-1:0]  intEn;
      logic [NUM_EV-1:0]  intStat;
      logic               awHave;
      logic [7:0]         awAddr;
      logic               wHave;
      logic [31:0]        wDat;
      logic [3:0]         wStb;
      logic               bValid;
      logic [1:0]         bResp;
      logic               rValid;
      logic [31:0]        rDat;
      logic [1:0]         rResp;
      logic               ackPend;
      logic               tdoPend;
      logic               strPend;
      logic               eovPend;
      logic               stWait;
      logic [7:0]         eovVid;
      logic [FAULT_W-1:0] faults;
      msg_t               kind;
      logic               busy;
      logic               start;
      logic               devReset;
      logic               stStart;
   } state_t;
   state_t q, d;
   logic       cmdValid;
   logic       badFrame;
   logic [7:0] cmdId;
   logic [7:0] msgIdx;
   logic [7:0] msgByte;
   logic [7:0] msgLen;
   logic       txDone;
   logic [NUM_EV-1:0] ev;
   logic [NUM_EV-1:0] clr;
   logic [6:0] si;
   logic [31:0] wMerged;

   function automatic logic [31:0] laneMerge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] stb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (stb[i]) r[8*i +: 8] = nw[8*i +: 8];
      end
      return r;
   endfunction : laneMerge

   function automatic logic [31:0] ctrlWord(input state_t s);
      return {16'h0000, s.syncFirst, 7'h00, s.ctrlEn};
   endfunction : ctrlWord

   frame_rx u_rx (
      .clk      (clk),
      .nrst     (nrst),
      .syncFirst(q.syncFirst),
      .rxValid  (rxValid),
      .rxData   (rxData),
      .cmdValid (cmdValid),
      .cmdId    (cmdId),
      .badFrame (badFrame)
   );

   frame_tx u_tx (
      .clk      (clk),
      .nrst     (nrst),
      .syncFirst(q.syncFirst),
      .start    (q.start),
      .msgLen   (msgLen),
      .msgByte  (msgByte),
      .msgIdx   (msgIdx),
      .done     (txDone),
      .txValid  (txValid),
      .txData   (txData),
      .txReady  (txReady)
   );

   // Message content by kind and byte index.
   always_comb begin
      si = msgIdx[6:0] - 7'h01;
      unique case (q.kind)
         K_ACK: begin
            msgLen = LEN_ACK;
            msgByte = MID_ACK;
         end
         K_EOV: begin
            msgLen = LEN_EOV;
            msgByte = (msgIdx == 8'h00) ? MID_EOV2 : q.eovVid;
         end
         K_STR: begin
            msgLen = LEN_STR;
            unique case (msgIdx)
               8'h00:   msgByte = MID_STR;
               8'h01:   msgByte = q.faults[7:0];
               default: msgByte = {4'h0, q.faults[FAULT_W-1:8]};
            endcase
         end
         default: begin
            msgLen = LEN_TDO;
            msgByte = (msgIdx == 8'h00) ? MID_TDO : q.scan[si];
         end
      endcase
   end

   always_comb begin
      d = q;
      d.start = 1'b0;
      d.devReset = 1'b0;
      d.stStart = 1'b0;
      ev = '0;
      clr = '0;
      wMerged = 32'h0;
      // Register writes complete once address and data have both arrived.
      if (awvalid && awready) begin
         d.awHave = 1'b1;
         d.awAddr = awaddr;
      end
      if (wvalid && wready) begin
         d.wHave = 1'b1;
         d.wDat = wdata;
         d.wStb = wstrb;
      end
      if (q.bValid && bready) d.bValid = 1'b0;
      if (q.awHave && q.wHave && !q.bValid) begin
         d.awHave = 1'b0;
         d.wHave = 1'b0;
         d.bValid = 1'b1;
         d.bResp = RESP_OKAY;
         unique case ({q.awAddr[7:2], 2'b00})
            OFF_CTRL: begin
               wMerged = laneMerge(ctrlWord(q), q.wDat, q.wStb);
               d.ctrlEn = wMerged[0];
               d.syncFirst = wMerged[15:8];
            end
            OFF_INTEN: begin
               wMerged = laneMerge({28'h0, q.intEn}, q.wDat, q.wStb);
               d.intEn = wMerged[NUM_EV-1:0];
            end
            OFF_INTCLR: begin
               wMerged = laneMerge(32'h0, q.wDat, q.wStb);
               clr = wMerged[NUM_EV-1:0];
            end
            OFF_STATUS, OFF_INTSTAT: d.bResp = RESP_OKAY;
            default: d.bResp = RESP_SLVERR;
         endcase
      end
      if (q.rValid && rready) d.rValid = 1'b0;
      if (arvalid && arready) begin
         d.rValid = 1'b1;
         d.rResp = RESP_OKAY;
         unique case ({araddr[7:2], 2'b00})
            OFF_CTRL:    d.rDat = ctrlWord(q);
            OFF_STATUS:  d.rDat = {4'h0, q.faults, q.eovVid, 7'h00, q.busy};
            OFF_INTSTAT: d.rDat = {28'h0, q.intStat};
            OFF_INTEN:   d.rDat = {28'h0, q.intEn};
            OFF_INTCLR:  d.rDat = 32'h0;
            default: begin
               d.rDat = 32'h0;
               d.rResp = RESP_SLVERR;
            end
         endcase
      end
      // Sender picks one pending message at a time; new events are
      // applied afterwards so that a set in the same cycle wins.
      if (!q.busy) begin
         if (q.eovPend) begin
            d.kind = K_EOV;
            d.eovPend = 1'b0;
            d.busy = 1'b1;
         end else if (q.strPend) begin
            d.kind = K_STR;
            d.strPend = 1'b0;
            d.busy = 1'b1;
         end else if (q.ackPend) begin
            d.kind = K_ACK;
            d.ackPend = 1'b0;
            d.busy = 1'b1;
         end else if (q.tdoPend) begin
            d.kind = K_TDO;
            d.tdoPend = 1'b0;
            d.busy = 1'b1;
         end
         d.start = d.busy;
      end else if (txDone) begin
         d.busy = 1'b0;
         ev[EV_STR] = (q.kind == K_STR);
         ev[EV_EOV] = (q.kind == K_EOV);
      end
      if (cmdValid && q.ctrlEn) begin
         ev[EV_CMD] = 1'b1;
         unique case (cmdId)
            CMD_RESET: begin
               d.devReset = 1'b1;
               d.ackPend = 1'b1;
            end
            CMD_TDO: d.tdoPend = 1'b1;
            CMD_SELFTEST: begin
               d.stStart = 1'b1;
               d.stWait = 1'b1;
            end
            default: begin
               ev[EV_CMD] = 1'b0;
               ev[EV_DROP] = 1'b1;
            end
         endcase
      end
      if (badFrame || (cmdValid && !q.ctrlEn)) ev[EV_DROP] = 1'b1;
      if (eovDone) begin
         d.eovPend = 1'b1;
         d.eovVid = vehicleId;
      end
      if (faultValid) begin
         d.faults = faultBits;
         d.stWait = 1'b0;
         if (q.stWait || (|faultBits)) d.strPend = 1'b1;
      end
      if (scanWe && (scanAddr < SCAN_TOTAL)) begin
         if (((scanAddr / SCAN_SEG) % 7'h02 == 7'h01) && scanWdata[7])
            d.scan[scanAddr] = INT_MAX;
         else
            d.scan[scanAddr] = scanWdata;
      end
      d.intStat = (q.intStat & ~clr) | ev;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) q <= '{ctrlEn: CTRL_EN_RST, syncFirst: SYNC_FIRST_RST,
                        kind: K_ACK, default: '0};
      else q <= d;
   end

   assign awready = !q.awHave;
   assign wready = !q.wHave;
   assign bvalid = q.bValid;
   assign bresp = q.bResp;
   assign arready = !q.rValid;
   assign rvalid = q.rValid;
   assign rdata = q.rDat;
   assign rresp = q.rResp;
   assign selfTestStart = q.stStart;
   assign devResetReq = q.devReset;
   assign irq = |(q.intStat & q.intEn);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_eov_ident: assert property (
      q.busy && q.kind == K_EOV && msgIdx == 8'h00 |-> msgByte == 8'h04)
      else $error("End message does not open with identifier 4.");
   a_eov_vehicle: assert property (
      eovDone && !q.busy |=> q.eovPend && q.eovVid == $past(vehicleId))
      else $error("End message lost its vehicle number.");
   a_reset_pulse: assert property (
      cmdValid && q.ctrlEn && cmdId == 8'h10 |=> devResetReq ##1 !devResetReq)
      else $error("Reset command did not give a one-cycle reset.");
   a_reset_ack: assert property (
      devResetReq |-> q.ackPend || (q.busy && q.kind == K_ACK))
      else $error("Reset gave no acknowledge.");
   a_dump_cause: assert property (
      $rose(q.tdoPend) |-> $past(cmdValid && q.ctrlEn && cmdId == 8'h11))
      else $error("Dump queued without a dump command.");
   a_dump_order: assert property (
      q.busy && q.kind == K_TDO && msgIdx == 8'h3d |-> msgByte == q.scan[60])
      else $error("Dump byte order is wrong.");
   a_intensity_cap: assert property (
      scanWe && scanAddr == 7'h1e |=> q.scan[30] <= 8'h7f)
      else $error("Intensity byte above 127.");
   a_selftest_go: assert property (
      cmdValid && q.ctrlEn && cmdId == 8'h07 |=> selfTestStart && q.stWait)
      else $error("Self-test command did not start the test.");
   a_report_unasked: assert property (
      faultValid && faultBits != 12'h000 |=> q.strPend || q.kind == K_STR)
      else $error("Failure produced no report.");
   a_fault_high: assert property (
      q.busy && q.kind == K_STR && msgIdx == 8'h02 |-> msgByte[7:4] == 4'h0)
      else $error("Unused fault bits not zero.");
   a_drop_quiet: assert property (
      badFrame && !q.busy && !q.ackPend && !q.tdoPend && !q.strPend
      && !q.eovPend && !eovDone && !faultValid |=> !q.busy)
      else $error("Dropped frame produced a reply.");
   c_dump: cover property (q.busy && q.kind == K_TDO ##[1:400] txDone);
   c_reset: cover property (devResetReq ##[1:40] txDone);
   c_report: cover property (selfTestStart ##[1:200] q.kind == K_STR && txDone);
   c_irq: cover property ($rose(irq));
endmodule : traffic_sensor_msg_handler
`default_nettype wire

// >>> dv/roadside_host.sv
/*
 Roadside computer model: sends command frames and collects reply bytes.
 Assumes the handler's byte links run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module roadside_host (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       txValid,
   input  wire logic [7:0] txData,
   output logic            txReady,
   output logic            rxValid,
   output logic [7:0]      rxData
);
   logic       slow;
   logic [7:0] got[$];

   initial begin
      slow    = 1'b0;
      txReady = 1'b0;
      rxValid = 1'b0;
      rxData  = 8'h00;
   end

   // Takes reply bytes, stalling every other cycle when slow.
   always @(posedge clk) begin
      if (txValid && txReady) begin
         got.push_back(txData);
      end
      txReady <= slow ? ~txReady : 1'b1;
   end

   // Sends a sync pair, one command byte and a checksum byte.
   task automatic send(input logic [7:0] first, input logic [7:0] cmd, input logic [7:0] sum);
      logic [7:0] b[4];
      b = '{first, 8'h5a, cmd, sum};
      for (int i = 0; i < 4; i++) begin
         rxValid <= 1'b1;
         rxData  <= b[i];
         @(posedge clk);
      end
      rxValid <= 1'b0;
      rxData  <= ~b[3];
      @(posedge clk);
   endtask : send
endmodule : roadside_host
`default_nettype wire

// >>> dv/tb.sv
/*
 Self-checking bench for the message handler: AXI4-Lite master, scan and
 event drivers beside a roadside computer model. Assumes a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb import tsm_pkg::*; ;
   logic               clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic               arvalid, arready, rvalid, rready, txValid, txReady, rxValid, irq;
   logic               eovDone, faultValid, selfTestStart, devResetReq, scanWe;
   logic [7:0]         awaddr, araddr, txData, rxData, vehicleId, scanWdata;
   logic [31:0]        wdata, rdata;
   logic [3:0]         wstrb, strb;
   logic [1:0]         bresp, rresp;
   logic [FAULT_W-1:0] faultBits;
   logic [6:0]         scanAddr;
   int                 miscompares, compares, resets, tests;

   traffic_sensor_msg_handler uut (.*);
   roadside_host host (.*);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (devResetReq) resets++;
      if (selfTestStart) tests++;
   end

   task automatic complete_run();
      if (miscompares == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   task automatic hang();
      miscompares++;
      complete_run();
   endtask : hang

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (++n > 200) hang();
      end while (!bvalid);
      bready <= 1'b0;
      chk("bresp", 32'(bresp), 32'(er));
      @(posedge clk);
   endtask : axw

   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (++n > 200) hang();
      end while (!rvalid);
      rready <= 1'b0;
      chk("rdata", rdata, ed);
      chk("rresp", 32'(rresp), 32'(er));
      @(posedge clk);
   endtask : axr

   task automatic expect_frame(input string nm, input logic [7:0] m[$]);
      logic [7:0] x;
      logic [7:0] f[$];
      int         n;
      x = 8'h00;
      n = 0;
      foreach (m[i]) x ^= m[i];
      f = {SYNC_FIRST_RST, SYNC_SECOND, m, x};
      while (host.got.size() < f.size()) begin
         @(posedge clk);
         if (++n > 2000) hang();
      end
      foreach (f[i]) chk(nm, 32'(host.got[i]), 32'(f[i]));
      repeat (4) @(posedge clk);
      chk("frame length", 32'(host.got.size()), 32'(f.size()));
      host.got.delete();
   endtask : expect_frame

   task automatic reset_cmd();
      host.send(8'haa, CMD_RESET, CMD_RESET);
      expect_frame("ack", {MID_ACK});
      chk("devResetReq", resets, 1);
      chk("irq masked", 32'(irq), 0);
   endtask : reset_cmd

   task automatic dump_cmd();
      logic [7:0] m[$];
      logic [7:0] v;
      m = {MID_TDO};
      for (int i = 0; i < 120; i++) begin
         v = 8'(i * 2 + 7);
         scanWe <= 1'b1;
         scanAddr <= 7'(i);
         scanWdata <= v;
         @(posedge clk);
         if ((i / 30) % 2 == 1 && v > INT_MAX) v = INT_MAX;
         m.push_back(v);
      end
      scanWe <= 1'b0;
      host.slow <= 1'b1;
      chk("early dump", 32'(host.got.size()), 0);
      host.send(8'haa, CMD_TDO, CMD_TDO);
      expect_frame("dump", m);
      host.slow <= 1'b0;
   endtask : dump_cmd

   task automatic self_test();
      host.send(8'haa, CMD_SELFTEST, CMD_SELFTEST);
      repeat (4) @(posedge clk);
      chk("selfTestStart", tests, 1);
      chk("early report", 32'(host.got.size()), 0);
      faultValid <= 1'b1;
      faultBits <= 12'h5a5;
      @(posedge clk);
      faultValid <= 1'b0;
      expect_frame("report", {MID_STR, 8'ha5, 8'h05});
      faultValid <= 1'b1;
      faultBits <= 12'h800;
      @(posedge clk);
      faultValid <= 1'b0;
      expect_frame("unprompted", {MID_STR, 8'h00, 8'h08});
   endtask : self_test

   task automatic end_vehicle();
      vehicleId <= 8'hc3;
      eovDone <= 1'b1;
      @(posedge clk);
      eovDone <= 1'b0;
      expect_frame("eov", {MID_EOV2, 8'hc3});
      axr(OFF_STATUS, 32'h0800c300, RESP_OKAY);
      faultValid <= 1'b1;
      faultBits <= 12'h000;
      @(posedge clk);
      faultValid <= 1'b0;
      repeat (12) @(posedge clk);
      chk("clean result quiet", 32'(host.got.size()), 0);
   endtask : end_vehicle

   task automatic drops();
      axw(OFF_INTEN, 32'h2, RESP_OKAY);
      axw(OFF_INTCLR, 32'hf, RESP_OKAY);
      host.send(8'haa, CMD_RESET, 8'h11);
      host.send(8'haa, 8'h33, 8'h33);
      strb = 4'h1;
      axw(OFF_CTRL, 32'h00005500, RESP_OKAY);
      strb = 4'hf;
      axr(OFF_CTRL, 32'h0000aa00, RESP_OKAY);
      host.send(8'haa, CMD_RESET, CMD_RESET);
      repeat (8) @(posedge clk);
      chk("no reply", 32'(host.got.size()), 0);
      chk("resets", resets, 1);
      chk("irq raised", 32'(irq), 1);
      axw(OFF_INTCLR, 32'h2, RESP_OKAY);
      chk("irq cleared", 32'(irq), 0);
      axw(OFF_CTRL, 32'h0000aa01, RESP_OKAY);
   endtask : drops

   initial begin
      nrst = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, eovDone, faultValid, scanWe} = '0;
      {awaddr, araddr, vehicleId, scanWdata, scanAddr} = '0;
      {wdata, wstrb, faultBits} = '0;
      strb = 4'hf;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      axr(OFF_CTRL, 32'h0000aa01, RESP_OKAY);
      axr(OFF_INTSTAT, 32'h0, RESP_OKAY);
      axr(8'h40, 32'h0, RESP_SLVERR);
      axw(8'h40, 32'h1, RESP_SLVERR);
      reset_cmd();
      dump_cmd();
      self_test();
      end_vehicle();
      drops();
      complete_run();
   end
endmodule : tb
`default_nettype wire
